/* fbr_pkg.sv */
// Contract
// - repeat frames between electrical and optical channels both ways, content unchanged.
// - variants enable two to four channels, one or two of each kind.
// - optical channels default to the monitored mode.
// - monitored mode sends, checks and suppresses echoes, monitors and segments.
// - a failed or disturbed monitored link stops carrying traffic.
// - a segmented link lights its red indicator and asserts the fault contact.
// - a segmented link sends test frames and rejoins when both ends agree.
// - all fault conditions are ORed onto one group fault output.
// - an unconnected monitored channel reports a broken fiber.
// - frames go to all other channels; optical frames echo back on their channel.
// - unmonitored mode disables echo, monitoring and segmentation.
// - activity is shown only for forwarded frames, stretched to 300 ms.
package fbr_pkg;
   // ==========================================================
   // channel layout
   localparam int CH_NUM = 4;
   localparam int N_ELEC = 2;
   localparam int N_OPT = 2;
   localparam int OPT_BASE = 2;
   // ==========================================================
   // timing
   localparam int CLK_MHZ = 200;
   localparam int FRAME_IDLE_NS = 1000;
   localparam int IDLE_CYC = (FRAME_IDLE_NS * CLK_MHZ + 999) / 1000;
   localparam int ECHO_TIMEOUT_NS = 20000;
   localparam int ECHO_CYC = (ECHO_TIMEOUT_NS * CLK_MHZ) / 1000;
   localparam int LED_STRETCH_MS = 300;
   localparam int LED_STRETCH_CYC = LED_STRETCH_MS * CLK_MHZ * 1000;
   localparam int TEST_PERIOD_US = 1000;
   localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * CLK_MHZ;
   localparam int TEST_LEN_NS = 2000;
   localparam int TEST_LEN_CYC = (TEST_LEN_NS * CLK_MHZ + 999) / 1000;
   // ==========================================================
   // counter widths
   localparam int IDLE_W = 8;
   localparam int ECHO_W = 12;
   localparam int TLEN_W = 9;
   // ==========================================================
   // link supervision state
   typedef enum logic {LINK_UP, LINK_SEG} link_state_e;
   localparam link_state_e LINK_RESET = LINK_SEG;
endpackage

/* fbr_repeater.sv */
`timescale 1ns/1ps
`default_nettype none
module fbr_repeater #(
   parameter int LED_CYC = fbr_pkg::LED_STRETCH_CYC,
   parameter int TEST_CYC = fbr_pkg::TEST_PERIOD_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [fbr_pkg::N_ELEC-1:0] i_elec_en,
   input wire logic [fbr_pkg::N_OPT-1:0] i_opt_en,
   input wire logic [fbr_pkg::N_OPT-1:0] i_opt_unmon,
   input wire logic [fbr_pkg::N_ELEC-1:0] i_elec_rx,
   input wire logic [fbr_pkg::N_OPT-1:0] i_opt_rx,
   output logic [fbr_pkg::N_ELEC-1:0] o_elec_tx,
   output logic [fbr_pkg::N_OPT-1:0] o_opt_tx,
   output logic [fbr_pkg::CH_NUM-1:0] o_led_act,
   output logic [fbr_pkg::N_OPT-1:0] o_led_red,
   output logic o_fault
);
   import fbr_pkg::*;

   // ==========================================================
   // channel view
   logic [CH_NUM-1:0] rx;
   logic [CH_NUM-1:0] en;
   logic [CH_NUM-1:0] rx_act;
   logic [CH_NUM-1:0] elig;
   logic [CH_NUM-1:0] dest_ok;
   logic [N_OPT-1:0] mon;
   logic [IDLE_W-1:0] idle_cnt_reg [CH_NUM];
   link_state_e link_reg [N_OPT];
   logic [N_OPT-1:0] echo_wait_reg;
   logic [N_OPT-1:0] echo_seen_reg;
   logic [ECHO_W-1:0] echo_cnt_reg [N_OPT];
   logic [31:0] test_tmr_reg [N_OPT];
   logic [TLEN_W-1:0] test_len_reg [N_OPT];
   logic [N_OPT-1:0] test_wait_reg;
   logic [N_OPT-1:0] got_echo_reg;
   logic [N_OPT-1:0] peer_seen_reg;
   logic [31:0] led_cnt_reg [CH_NUM];
   logic busy_reg;
   logic [1:0] src_reg;
   logic start_ok;
   logic [1:0] start_src;
   logic fwd_start;
   logic fwd_data;
   logic fwd_on;
   logic [1:0] fwd_src;

   assign rx = {i_opt_rx, i_elec_rx};
   assign en = {i_opt_en, i_elec_en};
   assign mon = i_opt_en & ~i_opt_unmon; // monitored unless switched off
   assign fwd_start = !busy_reg && start_ok;
   // first sample of a frame passes on the edge that takes the source
   assign fwd_on = busy_reg || fwd_start;
   assign fwd_src = busy_reg ? src_reg : start_src;
   assign fwd_data = rx[fwd_src];

   // line activity: active until idle for a whole gap
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int c = 0; c < CH_NUM; c++) begin
            idle_cnt_reg[c] <= IDLE_W'(IDLE_CYC);
         end
      end else begin
         for (int c = 0; c < CH_NUM; c++) begin
            if (!rx[c]) begin
               idle_cnt_reg[c] <= '0;
            end else if (idle_cnt_reg[c] != IDLE_W'(IDLE_CYC)) begin
               idle_cnt_reg[c] <= idle_cnt_reg[c] + 1'b1;
            end
         end
      end
   end

   // source eligibility and destinations
   always_comb begin
      for (int c = 0; c < CH_NUM; c++) begin
         if (c < OPT_BASE) begin
            elig[c] = en[c];
            dest_ok[c] = en[c];
            rx_act[c] = idle_cnt_reg[c] != IDLE_W'(IDLE_CYC);
         end else begin
            elig[c] = en[c] && link_reg[c-OPT_BASE] == LINK_UP && !echo_wait_reg[c-OPT_BASE];
            dest_ok[c] = en[c] && link_reg[c-OPT_BASE] == LINK_UP;
            rx_act[c] = idle_cnt_reg[c] != IDLE_W'(IDLE_CYC);
         end
      end
   end

   // lowest active eligible channel takes the repeater
   always_comb begin
      start_ok = 1'b0;
      start_src = 2'h0;
      for (int c = CH_NUM - 1; c >= 0; c--) begin
         if (!rx[c] && elig[c]) begin
            start_ok = 1'b1;
            start_src = 2'(c);
         end
      end
   end

   // frame ownership
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         busy_reg <= 1'b0;
         src_reg <= 2'h0;
      end else if (fwd_start) begin
         busy_reg <= 1'b1;
         src_reg <= start_src;
      end else if (busy_reg && !rx_act[src_reg]) begin
         busy_reg <= 1'b0;
      end
   end

   // transmitters: forward, echo back, or test frames
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_elec_tx <= '1;
         o_opt_tx <= '1;
      end else begin
         for (int c = 0; c < N_ELEC; c++) begin
            o_elec_tx[c] <= (fwd_on && fwd_src != 2'(c) && dest_ok[c]) ? fwd_data : 1'b1;
         end
         for (int k = 0; k < N_OPT; k++) begin
            if (mon[k] && link_reg[k] == LINK_SEG) begin
               o_opt_tx[k] <= (test_len_reg[k] != '0) ? 1'b0 : (test_wait_reg[k] ? 1'b1 : rx[k+OPT_BASE]);
            end else if (fwd_on && fwd_src != 2'(k + OPT_BASE) && dest_ok[k+OPT_BASE]) begin
               o_opt_tx[k] <= fwd_data;
            end else if (fwd_on && fwd_src == 2'(k + OPT_BASE) && mon[k]) begin
               o_opt_tx[k] <= fwd_data;
            end else begin
               o_opt_tx[k] <= 1'b1;
            end
         end
      end
   end

   // echo supervision while the link is up, test frames and rejoin while segmented
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int k = 0; k < N_OPT; k++) begin
            link_reg[k] <= LINK_RESET;
            echo_cnt_reg[k] <= '0;
            test_tmr_reg[k] <= '0;
            test_len_reg[k] <= '0;
         end
         echo_wait_reg <= '0;
         echo_seen_reg <= '0;
         test_wait_reg <= '0;
         got_echo_reg <= '0;
         peer_seen_reg <= '0;
      end else begin
         for (int k = 0; k < N_OPT; k++) begin
            if (!mon[k]) begin
               link_reg[k] <= LINK_UP;
               echo_wait_reg[k] <= 1'b0;
               echo_seen_reg[k] <= 1'b0;
               echo_cnt_reg[k] <= '0;
               test_len_reg[k] <= '0;
               test_wait_reg[k] <= 1'b0;
            end else begin
               case (link_reg[k])
                  LINK_UP: begin
                     if (fwd_start && start_src != 2'(k + OPT_BASE)) begin
                        echo_wait_reg[k] <= 1'b1;
                        echo_seen_reg[k] <= 1'b0;
                        echo_cnt_reg[k] <= '0;
                     end else if (echo_wait_reg[k]) begin
                        if (!rx[k+OPT_BASE]) begin
                           echo_seen_reg[k] <= 1'b1;
                        end
                        if (echo_seen_reg[k] && !rx_act[k+OPT_BASE]) begin
                           echo_wait_reg[k] <= 1'b0;
                        end else if (!echo_seen_reg[k] && rx[k+OPT_BASE] && !busy_reg) begin
                           if (echo_cnt_reg[k] == ECHO_W'(ECHO_CYC - 1)) begin
                              link_reg[k] <= LINK_SEG;
                              echo_wait_reg[k] <= 1'b0;
                              test_tmr_reg[k] <= '0;
                              test_wait_reg[k] <= 1'b0;
                              got_echo_reg[k] <= 1'b0;
                              peer_seen_reg[k] <= 1'b0;
                           end else begin
                              echo_cnt_reg[k] <= echo_cnt_reg[k] + 1'b1;
                           end
                        end
                     end
                  end
                  LINK_SEG: begin
                     if (test_tmr_reg[k] == 32'(TEST_CYC - 1)) begin
                        test_tmr_reg[k] <= '0;
                        test_len_reg[k] <= TLEN_W'(TEST_LEN_CYC);
                        test_wait_reg[k] <= 1'b0;
                     end else begin
                        test_tmr_reg[k] <= test_tmr_reg[k] + 1'b1;
                        if (test_len_reg[k] == TLEN_W'(1)) begin
                           test_wait_reg[k] <= 1'b1;
                        end
                        if (test_len_reg[k] != '0) begin
                           test_len_reg[k] <= test_len_reg[k] - 1'b1;
                        end
                     end
                     if (!rx[k+OPT_BASE] && test_wait_reg[k]) begin
                        got_echo_reg[k] <= 1'b1;
                     end else if (!rx[k+OPT_BASE] && test_len_reg[k] == '0) begin
                        peer_seen_reg[k] <= 1'b1;
                     end
                     if (got_echo_reg[k] && peer_seen_reg[k] && !rx_act[k+OPT_BASE]) begin
                        link_reg[k] <= LINK_UP;
                        echo_wait_reg[k] <= 1'b0;
                        test_wait_reg[k] <= 1'b0;
                        test_len_reg[k] <= '0;
                     end
                  end
                  default: begin
                     link_reg[k] <= LINK_SEG;
                  end
               endcase
            end
         end
      end
   end

   // activity indicators, forwarded frames only
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int c = 0; c < CH_NUM; c++) begin
            led_cnt_reg[c] <= '0;
         end
         o_led_act <= '0;
      end else begin
         for (int c = 0; c < CH_NUM; c++) begin
            if (fwd_start && start_src == 2'(c)) begin
               led_cnt_reg[c] <= 32'(LED_CYC);
               o_led_act[c] <= 1'b1;
            end else begin
               if (led_cnt_reg[c] != '0) begin
                  led_cnt_reg[c] <= led_cnt_reg[c] - 1'b1;
               end
               o_led_act[c] <= led_cnt_reg[c] > 32'h00000001;
            end
         end
      end
   end

   // fault indication and group contact
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_led_red <= '0;
         o_fault <= 1'b0;
      end else begin
         for (int k = 0; k < N_OPT; k++) begin
            o_led_red[k] <= mon[k] && link_reg[k] == LINK_SEG;
         end
         o_fault <= |(mon & {link_reg[1] == LINK_SEG, link_reg[0] == LINK_SEG});
      end
   end

   // ==========================================================
   // checks
   a_fault_group: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_fault |-> |o_led_red)
      else $error("group fault without a segmented link");
   a_red_fault: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      |o_led_red |-> o_fault)
      else $error("red indicator without fault contact");
   a_echo_timeout: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (mon[0] && link_reg[0] == LINK_UP && echo_wait_reg[0] && !echo_seen_reg[0] && rx[2] && !busy_reg
      && !fwd_start && echo_cnt_reg[0] == ECHO_W'(ECHO_CYC - 1)) |=> link_reg[0] == LINK_SEG)
      else $error("missing echo did not segment link");
   a_echo_suppr: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (fwd_start && start_src >= 2'h2) |-> !echo_wait_reg[start_src[0]])
      else $error("echo taken as a forwarded frame");
   a_unmon_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!mon[1] && !$past(mon[1])) |-> (!echo_wait_reg[1] && link_reg[1] == LINK_UP && !o_led_red[1]))
      else $error("unmonitored channel still supervised");
   a_seg_blocks: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (link_reg[0] == LINK_SEG && mon[0]) |-> !(fwd_start && start_src == 2'h2))
      else $error("segmented link still feeds traffic");
   a_rejoin: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (mon[0] && $stable(mon[0]) && link_reg[0] == LINK_SEG && got_echo_reg[0] && peer_seen_reg[0] && !rx_act[2])
      |=> link_reg[0] == LINK_UP)
      else $error("link did not rejoin after test handshake");
   a_led_stretch: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (fwd_start && start_src == 2'h0) |=> o_led_act[0] [*3])
      else $error("activity indication too short");
endmodule
`default_nettype wire

/* fbr_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// peer repeater at the far end of one fiber, monitored mode
module fbr_peer #(
   parameter int DLY = 4,
   parameter int TPER = 300
) (
   input wire logic i_ref_clk,
   input wire logic i_rx,
   input wire logic i_cut,
   input wire logic i_test_on,
   input wire logic i_send,
   input wire logic i_send_bit,
   output logic o_tx
);
   logic [7:0] dly_reg = 8'hFF;
   int guard_reg = 0;
   int idle_reg = 0;
   int tst_reg = 0;
   logic echo;
   // echo path, muted while our own frame or test frame comes back
   assign echo = (guard_reg == 0) ? dly_reg[DLY-1] : 1'h1;
   // delay line, quiet counter, guard and test frame timer
   always_ff @(posedge i_ref_clk) begin
      dly_reg <= {dly_reg[6:0], i_rx};
      idle_reg <= (i_rx && tst_reg == 0) ? idle_reg + 1 : 0;
      if (i_send || tst_reg > 0) begin
         guard_reg <= 16;
      end else if (guard_reg > 0) begin
         guard_reg <= guard_reg - 1;
      end
      if (tst_reg > 0) begin
         tst_reg <= tst_reg - 1;
      end else if (i_test_on && idle_reg > TPER) begin
         tst_reg <= 20;
      end
   end
   // dark fiber reads as idle, no stale bits
   assign o_tx = i_cut ? 1'h1 : (i_send ? i_send_bit : (tst_reg > 0 ? 1'h0 : echo));
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
   import fbr_pkg::*;
   typedef struct packed {logic [3:0] mask; logic [15:0] pat;} note_s;
   logic i_ref_clk = 1'h0;
   logic i_reset = 1'h1;
   logic [1:0] elec_en, opt_en, unmon, elec_rx, elec_tx, opt_tx, led_red;
   logic [3:0] led_act;
   logic fault, opt1_rx, peer_tx, p_cut, p_test, p_send, p_bit, mon_en;
   wire [3:0] tx_all = {opt_tx, elec_tx};
   integer seed = 32'h4E3E;
   int error_cnt = 0;
   int cmp_count = 0;
   int n;
   note_s notes[$];
   int src_t [5] = '{0, 1, 2, 3, 0};
   logic [3:0] mask_t [5] = '{4'hE, 4'hD, 4'hF, 4'h7, 4'h4};
   // ==========================================================
   // clock, design and far end
   always #2.5 i_ref_clk = ~i_ref_clk;
   fbr_repeater #(.LED_CYC(20), .TEST_CYC(1000)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_elec_en(elec_en), .i_opt_en(opt_en), .i_opt_unmon(unmon), .i_elec_rx(elec_rx),
      .i_opt_rx({opt1_rx, peer_tx}), .o_elec_tx(elec_tx), .o_opt_tx(opt_tx), .o_led_act(led_act),
      .o_led_red(led_red), .o_fault(fault));
   fbr_peer #(.DLY(4), .TPER(300)) peer (.i_ref_clk(i_ref_clk), .i_rx(opt_tx[0]), .i_cut(p_cut),
      .i_test_on(p_test), .i_send(p_send), .i_send_bit(p_bit), .o_tx(peer_tx));
   // ==========================================================
   // verdict and end of run
   task automatic wrap_up();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // bounded wait on red indicator (0) or fiber tx (1) of optical channel 0
   task automatic wait_until(input int which, input logic v, input int lim, output int cnt);
      for (cnt = 0; cnt < lim; cnt++) begin
         if ((which == 0 ? led_red[0] : opt_tx[0]) === v) return;
         @(posedge i_ref_clk);
         #1;
      end
      error_cnt++;
      wrap_up();
   endtask
   // one 16 bit frame from a source channel, then the frame end gap
   task automatic send_frame(input int src, input logic [3:0] mask);
      logic [15:0] pat;
      pat = {1'h0, 15'($random(seed))};
      notes.push_back('{mask, pat});
      for (int i = 15; i >= 0; i--) begin
         case (src)
            0, 1: elec_rx[src] = pat[i];
            2: begin
               p_send = 1'h1;
               p_bit = pat[i];
            end
            default: opt1_rx = pat[i];
         endcase
         if (i == 12) `CHK(led_act[src], 1'h1)
         if (i == 4 && src < 2 && mask[2]) `CHK(led_act[2], 1'h0)
         @(posedge i_ref_clk);
         #1;
      end
      elec_rx = 2'h3;
      opt1_rx = 1'h1;
      p_send = 1'h0;
      p_bit = 1'h1;
      repeat (240) @(posedge i_ref_clk);
      #1;
      `CHK(led_act, 4'h0)
   endtask
   // ==========================================================
   // monitor: captures a frame on the tx lines, checks it against the oldest note
   initial begin : mon
      logic [15:0] cap [4];
      note_s nt;
      forever begin
         @(posedge i_ref_clk);
         #1;
         if (mon_en && tx_all !== 4'hF) begin
            for (int k = 0; k < 16; k++) begin
               for (int d = 0; d < 4; d++) cap[d][15-k] = tx_all[d];
               @(posedge i_ref_clk);
               #1;
            end
            if (notes.size() == 0) `CHK(tx_all, 4'h0)
            else begin
               nt = notes.pop_front();
               for (int d = 0; d < 4; d++) `CHK(cap[d], nt.mask[d] ? nt.pat : 16'hFFFF)
            end
         end
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      elec_en = 2'h3;
      opt_en = 2'h3;
      unmon = 2'h0;
      elec_rx = 2'h3;
      opt1_rx = 1'h1;
      p_cut = 1'h0;
      p_test = 1'h1;
      p_send = 1'h0;
      p_bit = 1'h1;
      mon_en = 1'h0;
      repeat (2) @(posedge i_ref_clk);
      #1 i_reset = 1'h0;
      @(posedge i_ref_clk);
      #1;
      `CHK({led_red, fault}, 3'h7)
      unmon[1] = 1'h1;
      wait_until(0, 1'h0, 20000, n);
      p_test = 1'h0;
      `CHK({led_red, fault}, 3'h0)
      repeat (400) @(posedge i_ref_clk);
      #1 mon_en = 1'h1;
      for (int k = 0; k < 5; k++) begin
         elec_en = (k == 4) ? 2'h1 : 2'h3;
         opt_en = (k == 4) ? 2'h1 : 2'h3;
         send_frame(src_t[k], mask_t[k]);
      end
      opt_en = 2'h3;
      elec_en = 2'h3;
      p_cut = 1'h1;
      send_frame(0, 4'hE);
      mon_en = 1'h0;
      wait_until(0, 1'h1, 6000, n);
      `CHK(n > ECHO_CYC - 300, 1'h1)
      `CHK({led_red, fault}, 3'h3)
      wait_until(1, 1'h0, 1200, n);
      wait_until(1, 1'h1, 500, n);
      mon_en = 1'h1;
      send_frame(0, 4'hA);
      `CHK(32'(notes.size()), 32'h0)
      wrap_up();
   end
endmodule
`default_nettype wire
